/* File: stb_defs.vh */
// constants for the storage test register bridge
`ifndef STB_DEFS_VH
`define STB_DEFS_VH
// parameter area, write only
`define STB_OFF_ADDR_LO   15'h0000
`define STB_OFF_ADDR_HI   15'h0004
`define STB_OFF_LEN_LO    15'h0008
`define STB_OFF_LEN_HI    15'h000c
`define STB_OFF_CMD       15'h0010
`define STB_OFF_PATT      15'h0014
`define STB_OFF_TIMEOUT   15'h0020
`define STB_OFF_CPARAM    15'h0200
// status area, read only
`define STB_OFF_STATUS    15'h0100
`define STB_OFF_ERRTYPE   15'h010c
`define STB_OFF_CSTATUS   15'h0300
// area decode on byte address bits [14:13] and [9:8]
`define STB_AREA_REGS     2'b00
`define STB_AREA_IDEN     2'b01
`define STB_AREA_CTM      2'b10
`define STB_SUB_PARAM     2'b00
`define STB_SUB_STATUS    2'b01
`define STB_SUB_CPARAM    2'b10
`define STB_SUB_CSTATUS   2'b11
// command field positions and codes
`define STB_CMD_LSB       0
`define STB_DEV_LSB       8
`define STB_CMD_IDENTIFY  3'h0
`define STB_CMD_SHUTDOWN  3'h1
`define STB_CMD_WRITE     3'h2
`define STB_CMD_READ      3'h3
`define STB_CMD_HEALTH    3'h4
`define STB_CMD_FLUSH     3'h6
// pattern select codes
`define STB_PATT_INC      3'h0
`define STB_PATT_DEC      3'h1
`define STB_PATT_ZERO     3'h2
`define STB_PATT_ONE      3'h3
// beats of 128 bits in a 512-byte block, minus one
`define STB_LAST_BEAT     5'h1f
// reset values
`define STB_RST_PATT      3'h0
`define STB_RST_TIMEOUT   32'h00000000
`define STB_RST_CPARAM    32'h00000000
`endif

/* File: stb_bridge.v */
// storage test register bridge: apb register port, register file, rams, pattern gen/check
// What this block does
// - except in the all-zero and all-one patterns, generator stamps each 512-byte block with a 64-bit address header, counting per block
// - checker compares read data to expected pattern, sets fail flag on mismatch
// - start write gives one-cycle start pulse; next clock write-active goes high if the length is nonzero
// - fifo write strobe high only while write-active and almost full was low one clock earlier
// - fifo write strobe is the count enable of the total-data counter
// - at end count write-active and write strobe drop in the same cycle
// - read enable follows only the empty flag, not start nor total count
// - each read enable advances checker data counter; header counter advances on the last beat of each block
// - all core-side data groups are 128 bits wide
// - identify buffer is 8 KB, 128-bit write port, 32-bit read port
// - byte write enables come from dword enables anded with the write strobe
// - custom buffer is true dual port, same dword conversion, register side writable
// - bus transactions become a 32-bit simple register port
// - write and read paths share one apb state machine; write value and read data are latched separately
// - one shared register address, never write and read in one cycle
// - register write pulses strobe with word address, value and four byte lanes
// - read request pulses with address; slave returns data with valid pulse
// - 0x0000-0x00ff and 0x0200-0x02ff are write-only parameter areas
// - 0x0100-0x01ff and 0x0300-0x03ff are read-only status areas
// - 0x2000-0x3fff reads identify buffer; 0x4000-0x5fff reads and writes custom ram
// - byte lanes are ignored; every write is full 32 bits
// - two-stage read mux, read valid is request delayed by two flops
// - writing a non-reserved code to the command register sends a command request to the core
// - command field 3 bits with fixed codes; 101 and 111 reserved
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`include "stb_defs.vh"
module stb_bridge (
   // clock, reset, enable
   input  wire         sys_clk_in,
   input  wire         rst_n_in,
   input  wire         clk_en_in,
   // apb slave
   input  wire         psel_in,
   input  wire         penable_in,
   input  wire         pwrite_in,
   input  wire [15:0]  paddr_in,
   input  wire [31:0]  pwdata_in,
   input  wire [3:0]   pstrb_in,
   output reg  [31:0]  prdata_out,
   output reg          pready_out,
   output reg          pslverr_out,
   // core control and status
   output reg          cmd_req_out,
   output reg  [2:0]   cmd_code_out,
   output reg  [1:0]   dev_sel_out,
   output reg  [47:0]  user_addr_out,
   output reg  [47:0]  user_len_out,
   output reg  [31:0]  timeout_out,
   output reg  [31:0]  custom_param_out,
   input  wire         core_busy_in,
   input  wire         core_error_in,
   input  wire [3:0]   dev_detect_in,
   input  wire [1:0]   error_dev_in,
   input  wire [31:0]  error_type_in,
   input  wire [31:0]  custom_status_in,
   // write data fifo
   input  wire         fifo_almost_full_flag_in,
   output reg          fifo_write_strobe_out,
   output reg  [127:0] fifo_write_data_out,
   // read data fifo
   input  wire         fifo_empty_in,
   output reg          fifo_read_enable_out,
   input  wire [127:0] fifo_read_data_in,
   // identify buffer, core side
   input  wire         iden_wr_en_in,
   input  wire [8:0]   iden_wr_addr_in,
   input  wire [3:0]   iden_dword_write_lanes_in,
   input  wire [127:0] iden_wr_data_in,
   // custom command buffer, core side
   input  wire         ctm_wr_en_in,
   input  wire [4:0]   ctm_addr_in,
   input  wire [3:0]   ctm_dword_write_lanes_in,
   input  wire [127:0] ctm_wr_data_in,
   output reg  [127:0] ctm_rd_data_out
);

   localparam ST_IDLE  = 4'b0001;
   localparam ST_WACK  = 4'b0010;
   localparam ST_RWAIT = 4'b0100;
   localparam ST_DONE  = 4'b1000;

   reg  [3:0]   state_r;
   reg          reg_write_strobe_r;
   reg          reg_read_request_r;
   reg  [12:0]  reg_word_address_r;
   reg  [31:0]  reg_write_value_r;
   reg  [3:0]   reg_byte_lanes_r;
   reg  [31:0]  reg_read_value_r;
   reg          rd_d1_r;
   reg          reg_read_valid_r;
   reg  [1:0]   area_r;
   reg  [31:0]  regs_mux_r;
   reg  [31:0]  iden_mux_r;
   reg  [31:0]  ctm_mux_r;
   reg  [2:0]   patt_sel_r;
   reg          pattern_write_start_pulse_r;
   reg          read_start_pulse_r;
   reg          write_transfer_active_r;
   reg  [52:0]  wr_cnt_r;
   reg  [47:0]  wr_addr_r;
   reg  [52:0]  rd_cnt_r;
   reg  [47:0]  rd_addr_r;
   reg  [127:0] exp_r;
   reg          cmp_valid_r;
   reg          fail_r;
   reg  [31:0]  iden_mem [0:2047];
   reg  [31:0]  ctm_mem [0:127];
   integer      k, j;

   wire [14:0]  byte_addr = {reg_word_address_r, 2'b00};
   wire [1:0]   area      = byte_addr[14:13];
   wire [1:0]   sub       = byte_addr[9:8];
   wire         in_regs   = (area == `STB_AREA_REGS) && (byte_addr[12:10] == 3'h0);
   wire [52:0]  wr_end    = {user_len_out, 5'h00};
   wire         wr_done   = fifo_write_strobe_out && (wr_cnt_r + 53'h1 == wr_end);
   wire         wr_wrap   = fifo_write_strobe_out && (wr_cnt_r[4:0] == `STB_LAST_BEAT);
   wire [52:0]  cur_beat  = wr_cnt_r + {52'h0, fifo_write_strobe_out};
   wire [47:0]  cur_addr  = wr_addr_r + {47'h0, wr_wrap};
   wire         strobe_nxt = write_transfer_active_r && !wr_done && !fifo_almost_full_flag_in;
   wire [15:0]  iden_be;
   wire [15:0]  ctm_be;
   wire         cmd_wr    = reg_write_strobe_r && in_regs && (byte_addr == `STB_OFF_CMD);
   wire [2:0]   cmd_field = reg_write_value_r[`STB_CMD_LSB +: 3];
   wire         cmd_ok    = (cmd_field != 3'h5) && (cmd_field != 3'h7);

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_be
         assign iden_be[g*4 +: 4] = {4{iden_dword_write_lanes_in[g] & iden_wr_en_in}};
         assign ctm_be[g*4 +: 4]  = {4{ctm_dword_write_lanes_in[g] & ctm_wr_en_in}};
      end
   endgenerate

   // builds one 128-bit beat; the header occupies dwords 0 and 1 of the first beat
   function [127:0] stb_patt;
      input [47:0] a;
      input [52:0] b;
      input [2:0]  sel;
      reg   [127:0] d;
      reg   [31:0]  w;
      integer       i;
      begin
         d = 128'h0;
         for (i = 0; i < 4; i = i + 1) begin
            w = {b[29:0], i[1:0]};
            d[i*32 +: 32] = (sel == `STB_PATT_DEC) ? ~w : w;
         end
         if (b[4:0] == 5'h00) begin
            d[63:0] = {16'h0000, a[47:32], a[31:0]};
         end
         if (sel == `STB_PATT_ZERO) begin
            d = 128'h0;
         end
         if (sel == `STB_PATT_ONE) begin
            d = {128{1'b1}};
         end
         stb_patt = d;
      end
   endfunction

   // apb front end; one request in flight so writes and reads never overlap
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r            <= ST_IDLE;
         reg_write_strobe_r <= 1'b0;
         reg_read_request_r <= 1'b0;
         reg_word_address_r <= 13'h0;
         reg_write_value_r  <= 32'h0;
         reg_byte_lanes_r   <= 4'h0;
         prdata_out         <= 32'h0;
         pready_out         <= 1'b0;
         pslverr_out        <= 1'b0;
      end else if (clk_en_in) begin
         reg_write_strobe_r <= 1'b0;
         reg_read_request_r <= 1'b0;
         pready_out         <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (psel_in && !penable_in) begin
                  reg_word_address_r <= paddr_in[14:2];
                  if (pwrite_in) begin
                     reg_write_strobe_r <= 1'b1;
                     reg_write_value_r  <= pwdata_in;
                     reg_byte_lanes_r   <= pstrb_in;
                     pready_out         <= 1'b1;
                     state_r            <= ST_WACK;
                  end else begin
                     reg_read_request_r <= 1'b1;
                     state_r            <= ST_RWAIT;
                  end
               end
            end
            ST_WACK: begin
               state_r <= ST_IDLE;
            end
            ST_RWAIT: begin
               if (reg_read_valid_r) begin
                  prdata_out <= reg_read_value_r;
                  pready_out <= 1'b1;
                  state_r    <= ST_DONE;
               end
            end
            ST_DONE: begin
               state_r <= ST_IDLE;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // register file writes; lanes are latched but every write lands as a full word
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         user_addr_out               <= 48'h0;
         user_len_out                <= 48'h0;
         timeout_out                 <= `STB_RST_TIMEOUT;
         custom_param_out            <= `STB_RST_CPARAM;
         patt_sel_r                  <= `STB_RST_PATT;
         cmd_req_out                 <= 1'b0;
         cmd_code_out                <= 3'h0;
         dev_sel_out                 <= 2'h0;
         pattern_write_start_pulse_r <= 1'b0;
         read_start_pulse_r          <= 1'b0;
      end else if (clk_en_in) begin
         cmd_req_out                 <= cmd_wr && cmd_ok;
         pattern_write_start_pulse_r <= cmd_wr && (cmd_field == `STB_CMD_WRITE);
         read_start_pulse_r          <= cmd_wr && (cmd_field == `STB_CMD_READ);
         if (reg_write_strobe_r && in_regs && (sub == `STB_SUB_PARAM)) begin
            case (byte_addr)
               `STB_OFF_ADDR_LO: user_addr_out[31:0]  <= reg_write_value_r;
               `STB_OFF_ADDR_HI: user_addr_out[47:32] <= reg_write_value_r[15:0];
               `STB_OFF_LEN_LO:  user_len_out[31:0]   <= reg_write_value_r;
               `STB_OFF_LEN_HI:  user_len_out[47:32]  <= reg_write_value_r[15:0];
               `STB_OFF_PATT:    patt_sel_r           <= reg_write_value_r[2:0];
               `STB_OFF_TIMEOUT: timeout_out          <= reg_write_value_r;
               `STB_OFF_CMD: begin
                  if (cmd_ok) begin
                     cmd_code_out <= cmd_field;
                     dev_sel_out  <= reg_write_value_r[`STB_DEV_LSB +: 2];
                  end
               end
               default: begin
               end
            endcase
         end
         if (reg_write_strobe_r && in_regs && (byte_addr == `STB_OFF_CPARAM)) begin
            custom_param_out <= reg_write_value_r;
         end
      end
   end

   // two-stage read: area-local mux, then area select
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_d1_r          <= 1'b0;
         reg_read_valid_r <= 1'b0;
         area_r           <= 2'h0;
         regs_mux_r       <= 32'h0;
         iden_mux_r       <= 32'h0;
         ctm_mux_r        <= 32'h0;
         reg_read_value_r <= 32'h0;
      end else if (clk_en_in) begin
         rd_d1_r          <= reg_read_request_r;
         reg_read_valid_r <= rd_d1_r;
         if (reg_read_request_r) begin
            area_r     <= in_regs ? `STB_AREA_REGS : area;
            iden_mux_r <= iden_mem[reg_word_address_r[10:0]];
            ctm_mux_r  <= ctm_mem[reg_word_address_r[6:0]];
            regs_mux_r <= 32'h0;
            if (in_regs && (sub == `STB_SUB_STATUS)) begin
               case (byte_addr)
                  `STB_OFF_STATUS: regs_mux_r <= {6'h0, error_dev_in, 4'h0, dev_detect_in,
                                                  13'h0, fail_r, core_error_in, core_busy_in};
                  `STB_OFF_ERRTYPE: regs_mux_r <= error_type_in;
                  default: regs_mux_r <= 32'h0;
               endcase
            end
            if (in_regs && (byte_addr == `STB_OFF_CSTATUS)) begin
               regs_mux_r <= custom_status_in;
            end
            if (!in_regs && (area == `STB_AREA_REGS)) begin
               area_r <= 2'h3;
            end
         end
         if (rd_d1_r) begin
            case (area_r)
               `STB_AREA_REGS: reg_read_value_r <= regs_mux_r;
               `STB_AREA_IDEN: reg_read_value_r <= iden_mux_r;
               `STB_AREA_CTM:  reg_read_value_r <= ctm_mux_r;
               default:        reg_read_value_r <= 32'h0;
            endcase
         end
      end
   end

   // identify buffer: 512 x 128 seen as 2048 x 32 on the register side
   always @(posedge sys_clk_in) begin
      if (clk_en_in) begin
         for (k = 0; k < 4; k = k + 1) begin
            if (iden_be[k*4]) begin
               iden_mem[{iden_wr_addr_in, k[1:0]}] <= iden_wr_data_in[k*32 +: 32];
            end
         end
      end
   end

   // custom buffer: core port writes win over a register write to the same dword
   always @(posedge sys_clk_in) begin
      if (clk_en_in) begin
         if (reg_write_strobe_r && (area == `STB_AREA_CTM)) begin
            ctm_mem[reg_word_address_r[6:0]] <= reg_write_value_r;
         end
         for (j = 0; j < 4; j = j + 1) begin
            if (ctm_be[j*4]) begin
               ctm_mem[{ctm_addr_in, j[1:0]}] <= ctm_wr_data_in[j*32 +: 32];
            end
         end
      end
   end

   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctm_rd_data_out <= 128'h0;
      end else if (clk_en_in) begin
         ctm_rd_data_out <= {ctm_mem[{ctm_addr_in, 2'h3}], ctm_mem[{ctm_addr_in, 2'h2}],
                             ctm_mem[{ctm_addr_in, 2'h1}], ctm_mem[{ctm_addr_in, 2'h0}]};
      end
   end

   // generator; a zero length never starts, so it cannot run forever
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         write_transfer_active_r <= 1'b0;
         fifo_write_strobe_out   <= 1'b0;
         fifo_write_data_out     <= 128'h0;
         wr_cnt_r                <= 53'h0;
         wr_addr_r               <= 48'h0;
      end else if (clk_en_in) begin
         if (pattern_write_start_pulse_r) begin
            write_transfer_active_r <= (user_len_out != 48'h0);
            fifo_write_strobe_out   <= 1'b0;
            wr_cnt_r                <= 53'h0;
            wr_addr_r               <= user_addr_out;
         end else begin
            fifo_write_strobe_out <= strobe_nxt;
            if (fifo_write_strobe_out) begin
               wr_cnt_r <= wr_cnt_r + 53'h1;
            end
            if (wr_wrap) begin
               wr_addr_r <= wr_addr_r + 48'h1;
            end
            if (wr_done) begin
               write_transfer_active_r <= 1'b0;
            end
            if (strobe_nxt) begin
               fifo_write_data_out <= stb_patt(cur_addr, cur_beat, patt_sel_r);
            end
         end
      end
   end

   // checker; read data is taken one cycle after the enable
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fifo_read_enable_out <= 1'b0;
         rd_cnt_r             <= 53'h0;
         rd_addr_r            <= 48'h0;
         exp_r                <= 128'h0;
         cmp_valid_r          <= 1'b0;
         fail_r               <= 1'b0;
      end else if (clk_en_in) begin
         fifo_read_enable_out <= !fifo_empty_in;
         cmp_valid_r          <= fifo_read_enable_out;
         if (fifo_read_enable_out) begin
            exp_r <= stb_patt(rd_addr_r, rd_cnt_r, patt_sel_r);
         end
         if (read_start_pulse_r) begin
            rd_cnt_r  <= 53'h0;
            rd_addr_r <= user_addr_out;
         end else if (fifo_read_enable_out) begin
            rd_cnt_r <= rd_cnt_r + 53'h1;
            if (rd_cnt_r[4:0] == `STB_LAST_BEAT) begin
               rd_addr_r <= rd_addr_r + 48'h1;
            end
         end
         // a mismatch in the clearing cycle still sets the flag
         if (cmp_valid_r && (fifo_read_data_in != exp_r)) begin
            fail_r <= 1'b1;
         end else if (read_start_pulse_r) begin
            fail_r <= 1'b0;
         end
      end
   end

endmodule

/* File: stb_bridge_sva.sv */
// concurrent checks on the bridge ports
`timescale 1ns/1ns
module stb_bridge_sva (
   // clock and reset
   input wire         sys_clk_in,
   input wire         rst_n_in,
   // apb
   input wire         psel_in,
   input wire         penable_in,
   input wire         pwrite_in,
   input wire [15:0]  paddr_in,
   input wire [31:0]  pwdata_in,
   input wire         pready_out,
   input wire         pslverr_out,
   // core and fifo
   input wire         cmd_req_out,
   input wire [2:0]   cmd_code_out,
   input wire         fifo_almost_full_flag_in,
   input wire         fifo_write_strobe_out,
   input wire         fifo_empty_in,
   input wire         fifo_read_enable_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   // completing write to the command word; codes 101 and 111 are reserved
   wire cmd_wr = psel_in & penable_in & pwrite_in & pready_out & (paddr_in[14:2] == 13'h4);
   wire rsv    = pwdata_in[2] & pwdata_in[0];
   property p_wr; psel_in && !penable_in && pwrite_in |=> pready_out; endproperty
   property p_rd; psel_in && !penable_in && !pwrite_in |=> !pready_out [*3] ##1 pready_out;
   endproperty
   property p_one; pready_out |=> !pready_out; endproperty
   property p_err; !pslverr_out; endproperty
   property p_wstb; fifo_write_strobe_out |-> !$past(fifo_almost_full_flag_in); endproperty
   property p_rden; fifo_read_enable_out == !$past(fifo_empty_in); endproperty
   property p_req; cmd_wr && !rsv |-> ##[1:2] cmd_req_out; endproperty
   property p_rsv; cmd_wr && rsv |-> ##1 !cmd_req_out [*3]; endproperty
   property p_code; cmd_req_out |-> cmd_code_out != 3'h5 && cmd_code_out != 3'h7; endproperty
   property p_pulse; cmd_req_out |=> !cmd_req_out; endproperty
   a_wr: assert property (p_wr) else $error("write answer late");
   a_rd: assert property (p_rd) else $error("read latency wrong");
   a_one: assert property (p_one) else $error("pready too long");
   a_err: assert property (p_err) else $error("slave error seen");
   a_wstb: assert property (p_wstb) else $error("write while almost full");
   a_rden: assert property (p_rden) else $error("read enable not from empty");
   a_req: assert property (p_req) else $error("command request missing");
   a_rsv: assert property (p_rsv) else $error("reserved command issued");
   a_code: assert property (p_code) else $error("reserved code out");
   a_pulse: assert property (p_pulse) else $error("request not a pulse");
   c_wr: cover property (cmd_wr && !rsv);
   c_stall: cover property (fifo_almost_full_flag_in && fifo_write_strobe_out);
   c_rd: cover property (fifo_read_enable_out [*2]);
endmodule
bind stb_bridge stb_bridge_sva u_sva (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
   .cmd_req_out(cmd_req_out), .cmd_code_out(cmd_code_out),
   .fifo_almost_full_flag_in(fifo_almost_full_flag_in),
   .fifo_write_strobe_out(fifo_write_strobe_out), .fifo_empty_in(fifo_empty_in),
   .fifo_read_enable_out(fifo_read_enable_out));

/* File: stb_core_model.sv */
// core-side fifo model: takes generated beats and loops them back as read data
`timescale 1ns/1ns
module stb_core_model (
   // clock and reset
   input  wire          sys_clk_in,
   input  wire          rst_n_in,
   // bench control
   input  wire          hold_in,
   input  wire          corrupt_in,
   output logic [7:0]   depth_out,
   // write fifo
   input  wire          fifo_write_strobe_in,
   input  wire [127:0]  fifo_write_data_in,
   output logic         fifo_almost_full_flag_out,
   // read fifo
   input  wire          fifo_read_enable_in,
   output logic         fifo_empty_out,
   output logic [127:0] fifo_read_data_out
);
   logic [127:0] q[$];
   integer       cnt;
   logic [2:0]   cyc;
   logic         bad;
   assign depth_out = cnt[7:0];
   // empty looks one read ahead, since the enable trails empty by a cycle
   assign fifo_empty_out = hold_in || (cnt <= fifo_read_enable_in);
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q.delete();
         cnt <= 0;
         cyc <= 3'h0;
         bad <= 1'b0;
         fifo_almost_full_flag_out <= 1'b0;
         fifo_read_data_out <= 128'h0;
      end else begin
         cyc <= cyc + 3'h1;
         fifo_almost_full_flag_out <= (cyc == 3'h5);
         if (fifo_write_strobe_in) q.push_back(fifo_write_data_in);
         cnt <= cnt + fifo_write_strobe_in - fifo_read_enable_in;
         // idle read data is inverted every cycle, so stale data looks right again on every second idle cycle
         if (fifo_read_enable_in) begin
            fifo_read_data_out <= q.pop_front() ^ {127'h0, corrupt_in & !bad};
            bad <= corrupt_in;
         end else begin
            fifo_read_data_out <= ~fifo_read_data_out;
         end
      end
   end
endmodule

/* File: stb_testbench.sv */
// register, ram and pattern stream tests of the bridge
`timescale 1ns/1ns
module testbench;
   logic         clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic         hold = 1, corrupt = 0, busy = 1, mem_en = 0, cerr = 1;
   logic [15:0]  paddr = 0;
   logic [31:0]  pwdata = 0, rdat, cst = 32'h0c0ffee1, ety = 32'h00e00012;
   logic [3:0]   lanes = 0, detect = 4'h9;
   logic [127:0] mem_d = 0, wbeat [0:63];
   logic [2:0]   expc;
   integer       err_count = 0, cmp_count = 0, nbeat = 0, nreq = 0, n, p, c;
   wire  [31:0]  prdata, tmo, cpar;
   wire  [127:0] wd, rd_d, ctm_q;
   wire  [2:0]   code;
   wire  [1:0]   dsel;
   wire  [7:0]   depth;
   wire          rdy, req, af, wstb, empty, ren;
   always #4 clk = ~clk;
   always @(posedge clk) begin
      if (wstb && nbeat < 64) wbeat[nbeat] = wd;
      if (wstb) nbeat = nbeat + 1;
      if (req) nreq = nreq + 1;
   end
   stb_bridge u_stb_bridge (.sys_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(1'b1),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .pstrb_in(4'h0), .prdata_out(prdata), .pready_out(rdy),
      .pslverr_out(), .cmd_req_out(req), .cmd_code_out(code), .dev_sel_out(dsel),
      .user_addr_out(), .user_len_out(), .timeout_out(tmo), .custom_param_out(cpar),
      .core_busy_in(busy), .core_error_in(cerr), .dev_detect_in(detect),
      .error_dev_in(2'h2), .error_type_in(ety), .custom_status_in(cst),
      .fifo_almost_full_flag_in(af), .fifo_write_strobe_out(wstb),
      .fifo_write_data_out(wd), .fifo_empty_in(empty), .fifo_read_enable_out(ren),
      .fifo_read_data_in(rd_d), .iden_wr_en_in(mem_en), .iden_wr_addr_in(9'h3),
      .iden_dword_write_lanes_in(lanes), .iden_wr_data_in(mem_d), .ctm_wr_en_in(mem_en),
      .ctm_addr_in(5'h3), .ctm_dword_write_lanes_in(lanes), .ctm_wr_data_in(mem_d),
      .ctm_rd_data_out(ctm_q));
   stb_core_model u_stb_core_model (.sys_clk_in(clk), .rst_n_in(rst_n), .hold_in(hold),
      .corrupt_in(corrupt), .depth_out(depth), .fifo_write_strobe_in(wstb),
      .fifo_write_data_in(wd), .fifo_almost_full_flag_out(af),
      .fifo_read_enable_in(ren), .fifo_empty_out(empty), .fifo_read_data_out(rd_d));
   task final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input string nm, input logic [127:0] got, input logic [127:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task tmo_chk(input logic ok);
      if (!ok) begin
         err_count++;
         final_report;
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      integer k;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      k = 0;
      @(posedge clk);
      while (rdy !== 1'b1 && k < 20) begin
         @(posedge clk);
         k++;
      end
      rdat = prdata;
      psel <= 0;
      penable <= 0;
      tmo_chk(k < 20);
      @(posedge clk);
   endtask
   task mem_wr(input logic [3:0] l, input logic [127:0] d);
      mem_en <= 1;
      lanes <= l;
      mem_d <= d;
      @(posedge clk);
      mem_en <= 0;
      @(posedge clk);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      apb(1, 16'h0020, 32'h1234abcd);
      chk("timeout", tmo, 32'h1234abcd);
      apb(0, 16'h0020, 0); chk("wo_read", rdat, 0);
      apb(0, 16'h1000, 0); chk("unmapped", rdat, 0);
      apb(1, 16'h0200, 32'h5a5a0001); chk("cparam", cpar, 32'h5a5a0001);
      apb(0, 16'h0300, 0); chk("cstatus", rdat, cst);
      apb(0, 16'h010c, 0); chk("errtype", rdat, ety);
      mem_wr(4'b1111, {32'h3, 32'h2, 32'h1, 32'h0});
      mem_wr(4'b0101, {32'hd3, 32'hd2, 32'hd1, 32'hd0});
      apb(1, 16'h2030, 32'h77); // identify ram is read only
      apb(0, 16'h2030, 0); chk("iden0", rdat, 32'hd0);
      apb(0, 16'h2034, 0); chk("iden1", rdat, 32'h1);
      apb(0, 16'h2038, 0); chk("iden2", rdat, 32'hd2);
      apb(0, 16'h4034, 0); chk("ctm1", rdat, 32'h1);
      apb(1, 16'h4034, 32'h600d0001);
      apb(0, 16'h4034, 0); chk("ctm_reg", rdat, 32'h600d0001);
      chk("ctm_core", ctm_q[63:0], {32'h600d0001, 32'hd0});
      apb(1, 16'h0000, 32'h5); apb(1, 16'h0004, 0);
      apb(1, 16'h0008, 32'h2); apb(1, 16'h000c, 0);
      for (p = 0; p < 2; p++) begin
         hold <= 1;
         corrupt <= p;
         nbeat = 0;
         apb(1, 16'h0014, p);
         apb(1, 16'h0010, 32'h2);
         for (n = 0; n < 3000 && nbeat < 64; n++) @(posedge clk);
         tmo_chk(nbeat >= 64);
         apb(1, 16'h0010, 32'h3);
         hold <= 0;
         for (n = 0; n < 3000 && depth !== 8'h0; n++) @(posedge clk);
         tmo_chk(n < 3000);
         apb(0, 16'h0100, 0);
         chk("status", rdat, {6'h0, 2'h2, 4'h0, detect, 13'h0, p[0], cerr, busy});
         chk("beats", nbeat, 64);
         chk("hdr0", wbeat[0][95:0], {32'h2 ^ {32{p[0]}}, 32'h0, 32'h5});
         chk("hdr1", wbeat[32][63:0], {32'h0, 32'h6});
         chk("beat1", wbeat[1][31:0], {30'd1, 2'd0} ^ {32{p[0]}});
      end
      hold <= 1;
      nreq = 0;
      expc = 3'h3;
      for (c = 0; c < 8; c++) begin
         apb(1, 16'h0010, {22'h0, 2'h1, 5'h0, c[2:0]});
         if (c != 5 && c != 7) expc = c[2:0];
         chk("cmd_code", code, expc);
      end
      chk("requests", nreq, 6);
      chk("dev_sel", dsel, 2'h1);
      final_report;
   end
endmodule
